// [hw/pbrs_deglitch.v]
// one pushbutton filter: delayed fall, debounced rise
// assumes input synchronous to clk_in, undriven input reads high
`timescale 1ns/1ns
`default_nettype none
`include "pbrs_map.vh"

module pbrs_deglitch #(
   parameter [39:0] FALL_CYC = `PBRS_DEGLITCH_CYC,
   parameter [39:0] RISE_CYC = `PBRS_DEGLITCH_CYC
) (
   // clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // button and filtered level
   input  wire        btn_in_n,
   output reg         level_out_n
);

   reg [`PBRS_CNT_W-1:0] cnt_reg;

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         level_out_n <= 1'b1;
         cnt_reg     <= `PBRS_CNT_ZERO;
      end else if (btn_in_n == level_out_n) begin
         cnt_reg <= `PBRS_CNT_ZERO;
      end else if (!btn_in_n && cnt_reg >= FALL_CYC - `PBRS_CNT_ONE) begin
         level_out_n <= 1'b0; // RULE7
         cnt_reg     <= `PBRS_CNT_ZERO;
      end else if (btn_in_n && cnt_reg >= RISE_CYC - `PBRS_CNT_ONE) begin
         level_out_n <= 1'b1; // RULE8
         cnt_reg     <= `PBRS_CNT_ZERO;
      end else begin
         cnt_reg <= cnt_reg + `PBRS_CNT_ONE;
      end
   end

endmodule
`default_nettype wire

// [hw/pbrs_supervisor.v]
// pushbutton reset supervisor: supply-low and manual reset to reset_out_n
// assumes synchronous inputs and a free-running 20 MHz clk_in
// Functional notes
// RULE1: reset output goes low as soon as supply_low_in is high.
// RULE2: after supply recovers, reset stays low one full reset pulse period, then releases.
// RULE3: the outside party holds the button low at least the setup delay to ask for a reset.
// RULE4: a completed setup delay yields one low reset pulse of the reset pulse period.
// RULE5: in dual mode both buttons must be low together for the whole setup delay.
// RULE6: one pulse per press; re-arm needs a button released and held low again.
// RULE7: each button passes a deglitch stage delaying its fall by the deglitch period.
// RULE8: button release is debounced inside the device.
// RULE9: in single mode soft_reset_out_n follows the debounced button.
// RULE10: setup delay is picked by select pin low, open or high.
// RULE11: in resistor mode setup delay in seconds is kilohms over 20.
// RULE12: undriven buttons read high and never start setup timing.
// RULE13: reset outputs are active low, push-pull or open-drain by parameter.
// RULE14: pin-selected setup delays are per-option parameters, option A by default.
// RULE15: reset pulse period is a per-variant parameter, 0.9 ms by default.
// RULE16: all delays are counters on one reference clock with derived terminal counts.
`timescale 1ns/1ns
`default_nettype none
`include "pbrs_map.vh"

module pbrs_supervisor #(
   // variant selection
   parameter         DUAL          = 0,
   parameter         OPEN_DRAIN    = 0,
   // timing in physical units
   parameter [39:0]  DEGLITCH_MS   = `PBRS_DEGLITCH_MS,
   parameter [39:0]  PULSE_TENTH_MS = `PBRS_PULSE_TENTH_MS,
   parameter [39:0]  SETUP_LO_TS   = `PBRS_SETUP_LO_TENTH_S,
   parameter [39:0]  SETUP_MID_TS  = `PBRS_SETUP_MID_TENTH_S,
   parameter [39:0]  SETUP_HI_TS   = `PBRS_SETUP_HI_TENTH_S,
   // terminal counts on the reference clock
   parameter [39:0]  DEGLITCH_CYC  = DEGLITCH_MS * (`PBRS_CLK_HZ / 1000),
   parameter [39:0]  PULSE_CYC     = (PULSE_TENTH_MS * `PBRS_CLK_HZ + 9999) / 10000,
   parameter [39:0]  SETUP_LO_CYC  = SETUP_LO_TS * (`PBRS_CLK_HZ / 10),
   parameter [39:0]  SETUP_MID_CYC = SETUP_MID_TS * (`PBRS_CLK_HZ / 10),
   parameter [39:0]  SETUP_HI_CYC  = SETUP_HI_TS * (`PBRS_CLK_HZ / 10),
   parameter [39:0]  CYC_PER_KOHM  = `PBRS_CLK_HZ / `PBRS_RES_DIV
) (
   // clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // supply comparator
   input  wire        supply_low_in,
   // pushbuttons, pulled high when undriven
   input  wire        pushbutton_in_n,
   input  wire        pushbutton_a_n,
   input  wire        pushbutton_b_n,
   // setup delay select
   input  wire [1:0]  sel_mode_in,
   input  wire [9:0]  sel_kohm_in,
   // reset outputs
   output reg         reset_out_n,
   output reg         reset_oe_out,
   output reg         soft_reset_out_n,
   output reg         soft_reset_oe_out
);

   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_SETUP = 3'h2;
   localparam [2:0] ST_WAIT  = 3'h4;

   // filtered buttons
   wire                  btn_a_db;
   wire                  btn_b_db;
   wire                  raw_a;
   wire                  raw_b;
   wire                  pressed;
   wire                  setup_done;
   // press timing
   reg  [2:0]            state_reg;
   reg  [`PBRS_CNT_W-1:0] setup_cnt_reg;
   reg  [`PBRS_CNT_W-1:0] pulse_cnt_reg;
   reg  [`PBRS_CNT_W-1:0] setup_lim;
   reg  [`PBRS_CNT_W-1:0] setup_term;
   reg                   fire;
   reg                   reset_next;

   // undriven pins already read high, so idle never starts timing
   generate
      if (DUAL != 0) begin : g_dual
         assign raw_a = pushbutton_a_n;
         assign raw_b = pushbutton_b_n;
      end else begin : g_single
         // second filter parked low so only the one button counts
         assign raw_a = pushbutton_in_n; // RULE12
         assign raw_b = 1'b0;
      end
   endgenerate

   // one filter per button, fall delayed and rise debounced
   pbrs_deglitch #(.FALL_CYC(DEGLITCH_CYC), .RISE_CYC(DEGLITCH_CYC)) u_dg_a (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .btn_in_n    (raw_a),
      .level_out_n (btn_a_db)
   );

   pbrs_deglitch #(.FALL_CYC(DEGLITCH_CYC), .RISE_CYC(DEGLITCH_CYC)) u_dg_b (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .btn_in_n    (raw_b),
      .level_out_n (btn_b_db)
   );

   assign pressed = !btn_a_db && !btn_b_db; // RULE5

   always @* begin
      case (sel_mode_in) // RULE10 RULE14
         `PBRS_SEL_LOW:  setup_lim = SETUP_LO_CYC;
         `PBRS_SEL_OPEN: setup_lim = SETUP_MID_CYC;
         `PBRS_SEL_HIGH: setup_lim = SETUP_HI_CYC;
         default:        setup_lim = {30'h0, sel_kohm_in} * CYC_PER_KOHM; // RULE11
      endcase
   end

   // terminal count; a zero delay fires on the first held cycle instead of wrapping
   always @* begin
      if (setup_lim == `PBRS_CNT_ZERO)
         setup_term = `PBRS_CNT_ZERO;
      else
         setup_term = setup_lim - `PBRS_CNT_ONE;
   end

   assign setup_done = (setup_cnt_reg >= setup_term); // RULE16

   // manual press state machine
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg     <= ST_IDLE;
         setup_cnt_reg <= `PBRS_CNT_ZERO;
         fire          <= 1'b0;
      end else begin
         fire <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               setup_cnt_reg <= `PBRS_CNT_ZERO;
               if (pressed) begin
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (!pressed) begin
                  state_reg <= ST_IDLE;
               end else if (setup_done) begin
                  fire      <= 1'b1; // RULE4
                  state_reg <= ST_WAIT;
               end else begin
                  setup_cnt_reg <= setup_cnt_reg + `PBRS_CNT_ONE;
               end
            end
            ST_WAIT: begin
               if (!pressed) begin
                  state_reg <= ST_IDLE; // RULE6
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // reset pulse timer shared by supply and manual sources
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pulse_cnt_reg <= `PBRS_CNT_ZERO;
      end else if (supply_low_in) begin
         pulse_cnt_reg <= PULSE_CYC; // RULE1 RULE2
      end else if (fire) begin
         pulse_cnt_reg <= PULSE_CYC; // RULE4 RULE15
      end else if (pulse_cnt_reg != `PBRS_CNT_ZERO) begin
         pulse_cnt_reg <= pulse_cnt_reg - `PBRS_CNT_ONE; // RULE2
      end
   end

   always @* begin
      if (supply_low_in) begin
         reset_next = 1'b0; // RULE1
      end else if (fire) begin
         reset_next = 1'b0; // RULE4
      end else if (pulse_cnt_reg > `PBRS_CNT_ONE) begin
         reset_next = 1'b0; // RULE2
      end else begin
         reset_next = 1'b1;
      end
   end

   // reset pin: push-pull drives both levels, open-drain only pulls low
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         reset_out_n  <= 1'b0;
         reset_oe_out <= 1'b1;
      end else if (OPEN_DRAIN != 0) begin
         reset_out_n  <= 1'b0; // RULE13
         reset_oe_out <= !reset_next;
      end else begin
         reset_out_n  <= reset_next; // RULE13
         reset_oe_out <= 1'b1;
      end
   end

   // soft reset pin mirrors the filtered button, parked in dual mode
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         soft_reset_out_n  <= 1'b1;
         soft_reset_oe_out <= 1'b0;
      end else if (DUAL != 0) begin
         soft_reset_out_n  <= 1'b0;
         soft_reset_oe_out <= 1'b0;
      end else if (OPEN_DRAIN != 0) begin
         soft_reset_out_n  <= 1'b0;
         soft_reset_oe_out <= !btn_a_db; // RULE9
      end else begin
         soft_reset_out_n  <= btn_a_db; // RULE9
         soft_reset_oe_out <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// [pkg/pbrs_map.vh]
// constants for the pushbutton reset supervisor
// assumes a 20 MHz reference clock on clk_in
`ifndef PBRS_MAP_VH
`define PBRS_MAP_VH

`define PBRS_CLK_HZ            20000000
// fall deglitch period in ms
`define PBRS_DEGLITCH_MS       20
// fall deglitch period in reference clock cycles (20 ms at 20 MHz)
`define PBRS_DEGLITCH_CYC      40'h61A80
// default reset pulse period in units of 0.1 ms (0.9 ms)
`define PBRS_PULSE_TENTH_MS    9
// setup delays in units of 0.1 s, low / open / high select (option A)
`define PBRS_SETUP_LO_TENTH_S  5
`define PBRS_SETUP_MID_TENTH_S 10
`define PBRS_SETUP_HI_TENTH_S  20
// resistor divisor, kohm per second of setup delay
`define PBRS_RES_DIV           20
// select pin encodings
`define PBRS_SEL_LOW           2'h0
`define PBRS_SEL_OPEN          2'h1
`define PBRS_SEL_HIGH          2'h2
`define PBRS_SEL_RES           2'h3
`define PBRS_CNT_W             40
`define PBRS_CNT_ZERO          40'h0
`define PBRS_CNT_ONE           40'h1

`endif

// [tb/pbrs_button_model.sv]
// pushbutton switch, pulled high when released
// assumes the bench calls press from its main sequence
`timescale 1ns/1ns
`default_nettype none
module pbrs_button_model (
   input  wire  clk_in,
   output logic btn_n_out
);
   initial btn_n_out = 1'b1;
   task automatic press(input int cyc);
      @(posedge clk_in) btn_n_out <= 1'b0;
      repeat (cyc) @(posedge clk_in);
      btn_n_out <= 1'b1;
   endtask
endmodule
`default_nettype wire

// [tb/pbrs_properties.sv]
// checker on the supervisor top ports
// assumes push-pull single mode with pulse 8, deglitch 4
`timescale 1ns/1ns
`default_nettype none
module pbrs_properties (
   input wire clk_in,
   input wire rst_in,
   input wire supply_low_in,
   input wire pushbutton_in_n,
   input wire reset_out_n,
   input wire reset_oe_out,
   input wire soft_reset_out_n
);
   default clocking dc @(posedge clk_in); endclocking
   default disable iff (rst_in);
   chk_supply_low_reset: assert property (supply_low_in |=> !reset_out_n)
      else $error("reset high during low supply");
   chk_recover_hold: assert property ($fell(supply_low_in) |=> !reset_out_n [*7])
      else $error("reset released early");
   chk_recover_release: assert property ($fell(supply_low_in) |-> ##[7:10] reset_out_n)
      else $error("reset not released");
   chk_pulse_width: assert property ($fell(reset_out_n) |-> !reset_out_n [*7])
      else $error("reset pulse too short");
   chk_push_pull: assert property (reset_oe_out)
      else $error("reset drive dropped");
   chk_glitch_hold: assert property (($fell(pushbutton_in_n) && soft_reset_out_n) |=> soft_reset_out_n [*4])
      else $error("button fall passed early");
   chk_soft_follow: assert property (!pushbutton_in_n [*8] |-> !soft_reset_out_n)
      else $error("soft reset not low");
   chk_release_high: assert property (pushbutton_in_n [*8] |-> soft_reset_out_n)
      else $error("soft reset not released");
   cover property ($rose(supply_low_in));
   cover property ($fell(reset_out_n) && !supply_low_in);
   cover property ($fell(soft_reset_out_n));
endmodule
bind pbrs_supervisor pbrs_properties pbrs_properties_inst (.clk_in(clk_in), .rst_in(rst_in),
   .supply_low_in(supply_low_in), .pushbutton_in_n(pushbutton_in_n), .reset_out_n(reset_out_n),
   .reset_oe_out(reset_oe_out), .soft_reset_out_n(soft_reset_out_n));
`default_nettype wire

// [tb/pbrs_supervisor_tb_top.sv]
// bench for the supervisor, single push-pull mode
// assumes shortened counts: deglitch 4, pulse 8, setup 16/24/32, 1 cycle per kohm
`timescale 1ns/1ns
`default_nettype none
module pbrs_supervisor_tb_top;
   // shortened timing, same values feed the design and the expectations
   localparam logic [39:0] TB_DEGLITCH  = 40'h4;
   localparam logic [39:0] TB_PULSE     = 40'h8;
   localparam logic [39:0] TB_SETUP_LO  = 40'h10;
   localparam logic [39:0] TB_SETUP_MID = 40'h18;
   localparam logic [39:0] TB_SETUP_HI  = 40'h20;
   localparam logic [39:0] TB_PER_KOHM  = 40'h1;
   logic       clk_in = 1'b0;
   logic       btn_a_n = 1'b1;
   logic       btn_b_n = 1'b1;
   logic       rst_in = 1'b1;
   logic       supply_low_in = 1'b0;
   logic [1:0] sel_mode_in = 2'h0;
   logic [9:0] sel_kohm_in = 10'h00A;
   wire        btn_n, rst_o, rst_oe, soft_o, soft_oe;
   wire        pin = rst_oe ? rst_o : 1'b1;
   wire        soft_pin = soft_oe ? soft_o : 1'b1;
   int         err_total = 0, n_tests = 0, pulses = 0, low_len = 0, last_len = 0, exp_pulses = 0;
   always #25 clk_in = ~clk_in;
   pbrs_button_model pbrs_button_model_inst (.clk_in(clk_in), .btn_n_out(btn_n));
   pbrs_supervisor #(.DEGLITCH_CYC(TB_DEGLITCH), .PULSE_CYC(TB_PULSE), .SETUP_LO_CYC(TB_SETUP_LO),
      .SETUP_MID_CYC(TB_SETUP_MID), .SETUP_HI_CYC(TB_SETUP_HI), .CYC_PER_KOHM(TB_PER_KOHM))
      pbrs_supervisor_inst (.clk_in(clk_in), .rst_in(rst_in),
      .supply_low_in(supply_low_in), .pushbutton_in_n(btn_n), .pushbutton_a_n(btn_a_n), .pushbutton_b_n(btn_b_n),
      .sel_mode_in(sel_mode_in), .sel_kohm_in(sel_kohm_in), .reset_out_n(rst_o), .reset_oe_out(rst_oe),
      .soft_reset_out_n(soft_o), .soft_reset_oe_out(soft_oe));
   // count low stretches of the reset pin
   always @(posedge clk_in) begin
      if (pin === 1'b0)
         low_len <= low_len + 1;
      else if (low_len > 0) begin
         pulses <= pulses + 1;
         last_len <= low_len;
         low_len <= 0;
      end
   end
   task automatic miss(input string m);
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic chk_int(input int got, input int exp);
      n_tests++;
      if (got != exp) miss("pulse count");
   endtask
   task automatic chk_len(input int got, input int exp);
      n_tests++;
      if (got < exp - 1 || got > exp + 2) miss("pulse length");
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) miss("soft reset level");
   endtask
   task automatic conclude;
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic settle;
      int i;
      repeat (20) @(posedge clk_in);
      for (i = 0; i < 300 && (pin !== 1'b1 || low_len != 0); i++) @(posedge clk_in);
      if (i == 300) begin
         miss("timeout");
         conclude();
      end
      repeat (5) @(posedge clk_in);
   endtask
   initial begin
      int su;
      void'($urandom(32'hb80e2f64));
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      // the pin low during reset ends as one counted low stretch
      exp_pulses++;
      repeat (5) @(posedge clk_in);
      supply_low_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      supply_low_in <= 1'b0;
      exp_pulses++;
      settle();
      chk_int(pulses, exp_pulses);
      chk_len(last_len, 5 + int'(TB_PULSE));
      for (int m = 0; m < 4; m++) begin
         sel_mode_in <= m[1:0];
         sel_kohm_in <= 10'(10 + $urandom % 30);
         // dual-mode buttons must be ignored by the single variant
         btn_a_n <= ($urandom % 2) != 0;
         btn_b_n <= ($urandom % 2) != 0;
         @(posedge clk_in);
         su = (m == 0) ? int'(TB_SETUP_LO) : (m == 1) ? int'(TB_SETUP_MID) : (m == 2) ? int'(TB_SETUP_HI)
            : int'(sel_kohm_in) * int'(TB_PER_KOHM);
         pbrs_button_model_inst.press(su / 2);
         settle();
         chk_int(pulses, exp_pulses);
         fork
            pbrs_button_model_inst.press(su + 40);
            begin
               repeat (su) @(posedge clk_in);
               chk_bit(soft_pin, 1'b0);
            end
         join
         exp_pulses++;
         settle();
         chk_int(pulses, exp_pulses);
         chk_len(last_len, int'(TB_PULSE));
         chk_bit(soft_pin, 1'b1);
      end
      // reset stretch, supply event and one press per select mode
      chk_int(pulses, 2 + 4);
      conclude();
   end
endmodule
`default_nettype wire
